//--- rtl/tsr_pkg.sv
// Package: register map, field positions and reset values of the touch/swipe status bank
package tsr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_PRODUCT_CODE = 8'h00;
  localparam logic [7:0] ADDR_FIRMWARE_VERSION = 8'h01;
  localparam logic [7:0] ADDR_SYSTEM_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_SWIPE_FLAGS = 8'h11;
  localparam logic [7:0] ADDR_TOUCH_OUTPUT = 8'h35;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h3d;
  localparam logic [7:0] ADDR_RAW_COUNT_HIGH = 8'h42;
  localparam logic [7:0] ADDR_RAW_COUNT_LOW = 8'h43;
  localparam logic [7:0] ADDR_BASELINE_HIGH = 8'h83;
  localparam logic [7:0] ADDR_BASELINE_LOW = 8'h84;
  localparam logic [7:0] ADDR_SWIPE_CONFIG = 8'hcb;
  // Swipe flags field positions
  localparam int SWF_PULSE = 7;
  localparam int SWF_TIMEOUT = 6;
  localparam int SWF_OCCURRED = 5;
  localparam int SWF_DUAL = 4;
  localparam int SWF_DIR = 3;
  localparam int SWF_AO_WARN = 2;
  localparam int SWF_FINAL = 1;
  localparam int SWF_START = 0;
  // Swipe config field positions
  localparam int SWC_THIRD_CH = 7;
  localparam int SWC_PULSES = 6;
  localparam int SWC_UI_HI = 5;
  localparam int SWC_UI_LO = 4;
  localparam int SWC_END_ZERO = 3;
  localparam int SWC_ZERO_STATE = 2;
  localparam int SWC_RELAXED = 1;
  localparam int SWC_SWIPE_MODE = 0;
  // System flags field positions
  localparam int SYS_LOW_POWER = 6;
  localparam int SYS_ACTIVE_HIGH = 5;
  localparam int SYS_PROJECTED = 4;
  localparam int SYS_FILTER_HALT = 3;
  localparam int SYS_TUNING = 2;
  localparam int SYS_NOISE = 1;
  localparam int SYS_NORMAL_POWER = 0;
  // Touch output field positions
  localparam int TOUCH_SWIPE_OUT = 7;
  localparam int TOUCH_UNUSED_HI = 6;
  localparam int TOUCH_UNUSED_LO = 4;
  localparam int TOUCH_CH_HI = 3;
  localparam int TOUCH_PROX = 0;
  localparam logic [2:0] TOUCH_UNUSED = 3'h0;
  localparam logic [3:0] TOUCH_RESET = 4'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] UI_DUAL = 2'h1;
  localparam logic [7:0] SWIPE_CONFIG_RESET = 8'h00;
  localparam logic [7:0] CHAN_MAX = 8'h03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : tsr_pkg

//--- rtl/tsr_status_regs.sv
// Touch/swipe controller information and status register bank
// ------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------
`timescale 1ns/1ps
module tsr_status_regs
  import tsr_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = 8'h5a,     // Arbitrary value
  parameter logic [7:0] FIRMWARE_VERSION = 8'h01  // Arbitrary value
)
(
  input wire logic clk,
  input wire logic rst_n,
  // Register access port from the serial interface
  input wire logic [tsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [tsr_pkg::DATA_W-1:0] reg_wdata,
  output logic [tsr_pkg::DATA_W-1:0] reg_rdata,
  // Status from the sensing core
  input wire logic low_power_flag,
  input wire logic active_high_out,
  input wire logic projected_cap,
  input wire logic filter_halt,
  input wire logic auto_tuning_busy,
  input wire logic noise_detect_en,
  input wire logic noise_detected,
  input wire logic normal_power,
  input wire logic state_timeout,
  input wire logic swipe_event,
  input wire logic swipe_reverse,
  input wire logic auto_off_warning_flag,
  input wire logic engine_final_state,
  input wire logic engine_start_state,
  input wire logic [2:0] touch_present,
  input wire logic prox_present,
  input wire logic [1:0] active_channel,
  input wire logic [15:0] raw_count,
  input wire logic [15:0] baseline_average,
  // Configuration to the sensing core, and the swipe output pin
  output logic third_channel_enable,
  output logic pulse_output_mode,
  output logic [1:0] gesture_interface_select,
  output logic end_zero_opt,
  output logic zero_state_opt,
  output logic states_relaxed_opt,
  output logic swipe_mode,
  output logic swipe_output_pin
);
  import tsr_pkg::*;

  // ------------------------------------------------------------
  // Captured status
  // ------------------------------------------------------------
  logic [7:0] sys_reg;
  logic [7:0] sys_next;
  logic timeout_reg;
  logic occurred_reg;
  logic dir_reg;
  logic ao_reg;
  logic final_reg;
  logic start_reg;
  logic swipe_toggle_reg;
  logic [3:0] touch_reg;
  logic [7:0] chan_reg;
  logic [15:0] count_reg;
  logic [15:0] base_reg;
  logic [7:0] swipe_config_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire hit_product_code = (reg_addr == ADDR_PRODUCT_CODE);
  wire hit_firmware_version = (reg_addr == ADDR_FIRMWARE_VERSION);
  wire hit_system_flags = (reg_addr == ADDR_SYSTEM_FLAGS);
  wire hit_swipe_flags = (reg_addr == ADDR_SWIPE_FLAGS);
  wire hit_touch_output = (reg_addr == ADDR_TOUCH_OUTPUT);
  wire hit_channel_select = (reg_addr == ADDR_CHANNEL_SELECT);
  wire hit_raw_count_high = (reg_addr == ADDR_RAW_COUNT_HIGH);
  wire hit_raw_count_low = (reg_addr == ADDR_RAW_COUNT_LOW);
  wire hit_baseline_high = (reg_addr == ADDR_BASELINE_HIGH);
  wire hit_baseline_low = (reg_addr == ADDR_BASELINE_LOW);
  wire hit_swipe_config = (reg_addr == ADDR_SWIPE_CONFIG);

  // Only two bytes take writes; writes to read-only bytes decode to nothing
  wire wr_swipe_flags = reg_wr && hit_swipe_flags;
  wire wr_swipe_config = reg_wr && hit_swipe_config;
  wire occurred_clear = wr_swipe_flags && !reg_wdata[SWF_OCCURRED];
  wire timeout_clear = wr_swipe_flags && !reg_wdata[SWF_TIMEOUT];
  wire ao_clear = wr_swipe_flags && !reg_wdata[SWF_AO_WARN];
  wire dual_active = (swipe_config_reg[SWC_UI_HI:SWC_UI_LO] == UI_DUAL);
  wire noise_seen = noise_detected && noise_detect_en;

  always_comb
  begin
    sys_next = ZERO_BYTE;
    sys_next[SYS_LOW_POWER] = low_power_flag;
    sys_next[SYS_ACTIVE_HIGH] = active_high_out;
    sys_next[SYS_PROJECTED] = projected_cap;
    sys_next[SYS_FILTER_HALT] = filter_halt;
    sys_next[SYS_TUNING] = auto_tuning_busy;
    sys_next[SYS_NOISE] = noise_seen;
    sys_next[SYS_NORMAL_POWER] = normal_power;
  end

  // ------------------------------------------------------------
  // Status registers
  // ------------------------------------------------------------
  // System flags follow their sources one clock late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_reg <= ZERO_BYTE;
    end
    else
    begin
      sys_reg <= sys_next;
    end
  end

  // Direction moves only on a recognised swipe, so it keeps the last one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_reg <= 1'b0;
    end
    else if (swipe_event)
    begin
      dir_reg <= swipe_reverse;
    end
  end

  // Engine position flags are plain levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      final_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      final_reg <= engine_final_state;
      start_reg <= engine_start_state;
    end
  end

  // Channel touches and proximity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      touch_reg <= TOUCH_RESET;
    end
    else
    begin
      touch_reg <= {touch_present, prox_present};
    end
  end

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // A set in the clearing cycle wins, so no event is lost to a host clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeout_reg <= 1'b0;
    end
    else
    begin
      timeout_reg <= state_timeout || (timeout_reg && !timeout_clear);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      occurred_reg <= 1'b0;
    end
    else
    begin
      occurred_reg <= swipe_event || (occurred_reg && !occurred_clear);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ao_reg <= 1'b0;
    end
    else
    begin
      ao_reg <= auto_off_warning_flag || (ao_reg && !ao_clear);
    end
  end

  // ------------------------------------------------------------
  // Swipe output
  // ------------------------------------------------------------
  // Level toggle; pulse/level form is handled by pin logic outside
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swipe_toggle_reg <= 1'b0;
    end
    else if (swipe_event)
    begin
      swipe_toggle_reg <= !swipe_toggle_reg;
    end
  end

  // ------------------------------------------------------------
  // Channel data
  // ------------------------------------------------------------
  // Captured on the same edge so number, count and average stay coherent
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_reg <= ZERO_BYTE;
    end
    else
    begin
      chan_reg <= DATA_W'(active_channel);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= COUNT_RESET;
    end
    else
    begin
      count_reg <= raw_count;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_reg <= COUNT_RESET;
    end
    else
    begin
      base_reg <= baseline_average;
    end
  end

  // ------------------------------------------------------------
  // Swipe configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swipe_config_reg <= SWIPE_CONFIG_RESET;
    end
    else if (wr_swipe_config)
    begin
      swipe_config_reg <= reg_wdata;
    end
  end

  assign third_channel_enable = swipe_config_reg[SWC_THIRD_CH];
  assign pulse_output_mode = swipe_config_reg[SWC_PULSES];
  assign gesture_interface_select = swipe_config_reg[SWC_UI_HI:SWC_UI_LO];
  assign end_zero_opt = swipe_config_reg[SWC_END_ZERO];
  assign zero_state_opt = swipe_config_reg[SWC_ZERO_STATE];
  assign states_relaxed_opt = swipe_config_reg[SWC_RELAXED];
  assign swipe_mode = swipe_config_reg[SWC_SWIPE_MODE];
  assign swipe_output_pin = swipe_toggle_reg;

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  // Swipe flags byte; bit 7 mirrors the pulse/level choice in the configuration
  wire [7:0] swipe_flags_val;
  assign swipe_flags_val[SWF_PULSE] = swipe_config_reg[SWC_PULSES];
  assign swipe_flags_val[SWF_TIMEOUT] = timeout_reg;
  assign swipe_flags_val[SWF_OCCURRED] = occurred_reg;
  assign swipe_flags_val[SWF_DUAL] = dual_active;
  assign swipe_flags_val[SWF_DIR] = dir_reg;
  assign swipe_flags_val[SWF_AO_WARN] = ao_reg;
  assign swipe_flags_val[SWF_FINAL] = final_reg;
  assign swipe_flags_val[SWF_START] = start_reg;
  wire [7:0] touch_val;
  assign touch_val[TOUCH_SWIPE_OUT] = swipe_toggle_reg;
  assign touch_val[TOUCH_UNUSED_HI:TOUCH_UNUSED_LO] = TOUCH_UNUSED;
  assign touch_val[TOUCH_CH_HI:TOUCH_PROX] = touch_reg;

  // Each byte is gated by its own address hit and the gated bytes are ORed together;
  // an address that hits nothing reads back as zero
  logic [7:0] sel_product_code;
  logic [7:0] sel_firmware_version;
  logic [7:0] sel_system_flags;
  logic [7:0] sel_swipe_flags;
  logic [7:0] sel_touch_output;
  logic [7:0] sel_channel_select;
  logic [7:0] sel_raw_count_high;
  logic [7:0] sel_raw_count_low;
  logic [7:0] sel_baseline_high;
  logic [7:0] sel_baseline_low;
  logic [7:0] sel_swipe_config;
  logic [7:0] sel_unmapped;
  wire hit_mapped = hit_product_code || hit_firmware_version || hit_system_flags || hit_swipe_flags ||
                    hit_touch_output || hit_channel_select || hit_raw_count_high || hit_raw_count_low ||
                    hit_baseline_high || hit_baseline_low || hit_swipe_config;
  assign sel_product_code = {DATA_W{hit_product_code}} & PRODUCT_CODE;
  assign sel_firmware_version = {DATA_W{hit_firmware_version}} & FIRMWARE_VERSION;
  assign sel_system_flags = {DATA_W{hit_system_flags}} & sys_reg;
  assign sel_swipe_flags = {DATA_W{hit_swipe_flags}} & swipe_flags_val;
  assign sel_touch_output = {DATA_W{hit_touch_output}} & touch_val;
  assign sel_channel_select = {DATA_W{hit_channel_select}} & chan_reg;
  assign sel_raw_count_high = {DATA_W{hit_raw_count_high}} & count_reg[15:8];
  assign sel_raw_count_low = {DATA_W{hit_raw_count_low}} & count_reg[7:0];
  assign sel_baseline_high = {DATA_W{hit_baseline_high}} & base_reg[15:8];
  assign sel_baseline_low = {DATA_W{hit_baseline_low}} & base_reg[7:0];
  assign sel_swipe_config = {DATA_W{hit_swipe_config}} & swipe_config_reg;
  assign sel_unmapped = {DATA_W{!hit_mapped}} & UNMAPPED_READ;

  assign rdata_next = sel_product_code | sel_firmware_version | sel_system_flags | sel_swipe_flags |
                      sel_touch_output | sel_channel_select | sel_raw_count_high | sel_raw_count_low |
                      sel_baseline_high | sel_baseline_low | sel_swipe_config | sel_unmapped;

  // ------------------------------------------------------------
  // Read data register
  // ------------------------------------------------------------
  // The byte for an address appears one clock after the address is presented
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= ZERO_BYTE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : tsr_status_regs

//--- verification/tb.sv
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module tb;
  import tsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic w;
  logic pin;
  logic [7:0] a, wd, rd, d;
  wire [7:0] o;
  logic [7:0] sf = 8'h00;
  logic [5:0] sw = 6'h00;
  logic [3:0] tp = 4'h0;
  logic [1:0] ch = 2'h0;
  logic [15:0] raw = 16'h0000;
  logic [15:0] bl = 16'h0000;
  logic [7:0] pat [5] = '{8'h7f, 8'hff, 8'h82, 8'h55, 8'h2a};
  int n_fail = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  tsr_host_model host_u (.clk(clk), .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rdata(rd));
  tsr_status_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(a), .reg_wr(w), .reg_wdata(wd), .reg_rdata(rd),
    .low_power_flag(sf[6]), .active_high_out(sf[5]), .projected_cap(sf[4]), .filter_halt(sf[3]),
    .auto_tuning_busy(sf[2]), .noise_detect_en(sf[7]), .noise_detected(sf[1]), .normal_power(sf[0]),
    .state_timeout(sw[0]), .swipe_event(sw[1]), .swipe_reverse(sw[2]), .auto_off_warning_flag(sw[3]),
    .engine_final_state(sw[4]), .engine_start_state(sw[5]), .touch_present(tp[3:1]), .prox_present(tp[0]),
    .active_channel(ch), .raw_count(raw), .baseline_average(bl), .third_channel_enable(o[7]),
    .pulse_output_mode(o[6]), .gesture_interface_select(o[5:4]), .end_zero_opt(o[3]), .zero_state_opt(o[2]),
    .states_relaxed_opt(o[1]), .swipe_mode(o[0]), .swipe_output_pin(pin));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_rd(input logic [7:0] ad, input logic [7:0] exp);
    host_u.rd(ad, d);
    check(d, exp);
  endtask : chk_rd
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(ADDR_PRODUCT_CODE, 8'h5a);
    host_u.wr(ADDR_PRODUCT_CODE, 8'hff);
    host_u.wr(ADDR_FIRMWARE_VERSION, 8'hff);
    chk_rd(ADDR_PRODUCT_CODE, 8'h5a);
    chk_rd(ADDR_FIRMWARE_VERSION, 8'h01);
    chk_rd(8'h20, 8'h00);
    foreach (pat[i])
    begin
      @(posedge clk);
      sf <= pat[i];
      chk_rd(ADDR_SYSTEM_FLAGS, {1'b0, pat[i][6:2], pat[i][1] & pat[i][7], pat[i][0]});
    end
    host_u.wr(ADDR_SWIPE_CONFIG, 8'h5b);
    #1 check(o, 8'h5b);
    chk_rd(ADDR_SWIPE_CONFIG, 8'h5b);
    @(posedge clk);
    sw <= 6'h1f;
    fork
      host_u.rd(ADDR_SWIPE_FLAGS, d);
      @(posedge clk) sw <= 6'h10;
    join
    check(d, 8'hfe);
    check({7'h00, pin}, 8'h01);
    host_u.wr(ADDR_SWIPE_FLAGS, 8'h00);
    chk_rd(ADDR_SWIPE_FLAGS, 8'h9a);
    @(posedge clk);
    tp <= 4'hb;
    ch <= 2'h3;
    raw <= 16'h1234;
    bl <= 16'habcd;
    sw <= 6'h20;
    chk_rd(ADDR_TOUCH_OUTPUT, 8'h8b);
    chk_rd(ADDR_CHANNEL_SELECT, 8'h03);
    chk_rd(ADDR_RAW_COUNT_HIGH, 8'h12);
    chk_rd(ADDR_RAW_COUNT_LOW, 8'h34);
    chk_rd(ADDR_BASELINE_HIGH, 8'hab);
    chk_rd(ADDR_BASELINE_LOW, 8'hcd);
    chk_rd(ADDR_SWIPE_FLAGS, 8'h99);
    host_u.wr(ADDR_SWIPE_CONFIG, 8'ha4);
    #1 check(o, 8'ha4);
    chk_rd(ADDR_SWIPE_FLAGS, 8'h09);
    tally_and_finish();
  end
endmodule : tb

//--- verification/tsr_host_model.sv
// Host-side register access model
`timescale 1ns/1ps
module tsr_host_model (
  input logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    repeat (3) @(posedge clk);
    #1 d = reg_rdata;
  endtask : rd
endmodule : tsr_host_model

//--- verification/tsr_status_regs_props.sv
// Concurrent checks on the status register bank ports
`timescale 1ns/1ps
module tsr_status_regs_props
  import tsr_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = 8'h5a
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic swipe_event,
  input wire logic [2:0] touch_present,
  input wire logic prox_present,
  input wire logic [1:0] active_channel,
  input wire logic third_channel_enable,
  input wire logic pulse_output_mode,
  input wire logic [1:0] gesture_interface_select,
  input wire logic swipe_mode,
  input wire logic swipe_output_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire cfg_wr = reg_wr && reg_addr == ADDR_SWIPE_CONFIG;
  wire [4:0] cfg_now = {third_channel_enable, pulse_output_mode, gesture_interface_select, swipe_mode};
  wire [4:0] cfg_in = {reg_wdata[7:4], reg_wdata[0]};
  sequence s_swipe_pulse;
    swipe_event ##1 !swipe_event;
  endsequence
  a_pin_toggles: assert property (swipe_event |=> swipe_output_pin != $past(swipe_output_pin))
    else $error("swipe pin did not toggle");
  a_pin_steady: assert property (!swipe_event |=> $stable(swipe_output_pin))
    else $error("swipe pin moved without a swipe");
  a_config_load: assert property (cfg_wr |=> cfg_now == $past(cfg_in))
    else $error("swipe config not loaded");
  a_config_hold: assert property (!cfg_wr |=> $stable(cfg_now))
    else $error("swipe config changed without a write");
  a_product_read: assert property (reg_addr == ADDR_PRODUCT_CODE && $past(rst_n) |=> reg_rdata == PRODUCT_CODE)
    else $error("product code read wrong");
  a_unmapped_read: assert property (reg_addr == 8'h20 |=> reg_rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_chan_read: assert property (reg_addr == ADDR_CHANNEL_SELECT && $past(rst_n) |=>
    reg_rdata == {6'h00, $past(active_channel, 2)}) else $error("channel select read wrong");
  a_touch_read: assert property (reg_addr == ADDR_TOUCH_OUTPUT && $past(rst_n) |=>
    reg_rdata[6:0] == {3'h0, $past(touch_present, 2), $past(prox_present, 2)}) else $error("touch byte wrong");
  a_occurred_set: assert property (s_swipe_pulse ##0 (reg_addr == ADDR_SWIPE_FLAGS && !reg_wr) [*2] |=>
    reg_rdata[SWF_OCCURRED]) else $error("swipe occurred flag not set");
endmodule : tsr_status_regs_props
bind tsr_status_regs tsr_status_regs_props #(.PRODUCT_CODE(PRODUCT_CODE)) chk_u (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .swipe_event(swipe_event),
  .touch_present(touch_present), .prox_present(prox_present), .active_channel(active_channel),
  .third_channel_enable(third_channel_enable), .pulse_output_mode(pulse_output_mode),
  .gesture_interface_select(gesture_interface_select), .swipe_mode(swipe_mode), .swipe_output_pin(swipe_output_pin));
